// >>> rtl/branch_or_inc_rotate_exec.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`include "exec_defs.svh"
`default_nettype none
// Operation
// RULE_01: jump puts eleven-bit operand into pc[10:0]
// RULE_02: jump fills pc[12:11] from page latch[4:3]
// RULE_03: jump unconditional, two cycles, flags untouched
// RULE_04: or literal into acc, zero flag only
// RULE_05: increment file, destination bit picks target
// RULE_06: or acc with file, destination picks target
// RULE_07: rotate left through carry, carry only
// RULE_08: msb to carry, carry to lsb
module branch_or_inc_rotate_exec
  import exec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [12:0] pc_o,
  output logic             busy_o
);

  // latched instruction and sequencer
  state_e      state_reg;          // sequencer state
  op_e         op_reg;             // operation being executed
  logic        dst_reg;            // destination bit
  logic [10:0] k_reg;              // operand field
  // architectural state
  logic [7:0]  acc_reg;            // working register
  logic        carry_reg;          // carry flag
  logic        zero_reg;           // zero flag
  logic [7:0]  page_reg;           // program_page_latch
  logic [7:0]  file_mem_reg [`FILE_DEPTH]; // file registers
  // bus data-phase bookkeeping
  logic        dph_wr_reg;         // write data phase in progress
  logic        dph_rd_reg;         // read wait state in progress
  logic [11:0] dph_addr_reg;       // address of the data phase
  // datapath results
  logic [7:0]  fval;               // selected file register
  logic [7:0]  res;                // operation result
  logic        acc_we;             // result goes to accumulator
  logic        file_we;            // result goes to file register
  logic        zero_we;            // operation updates zero
  logic        carry_we;           // operation updates carry
  logic        carry_new;          // new carry value
  logic [12:0] target;             // jump target
  logic        addr_ok;            // address phase accepted
  logic        wr_ok;              // bus write may commit
  logic        exec_now;           // execute cycle
  logic [7:0]  bus_byte;           // low byte of write data

  // true when the data-phase address hits a given register
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  // true when the address falls in the file window
  function automatic logic in_file(input logic [11:0] a);
    in_file = (a[`A_FILE_SEL] == `A_FILE_HI);
  endfunction

  assign addr_ok  = hsel_i & htrans_i[1] & hready_i;
  // writes arriving while busy are dropped: no race with the datapath
  assign wr_ok    = dph_wr_reg & (state_reg == ST_IDLE);
  assign exec_now = (state_reg == ST_EXEC);
  assign bus_byte = hwdata_i[7:0];
  assign fval     = file_mem_reg[k_reg[`K_FILE]];

  // datapath for the latched instruction
  exec_alu u_alu (
    .op_i        (op_reg),
    .dst_i       (dst_reg),
    .k_i         (k_reg),
    .acc_i       (acc_reg),
    .fval_i      (fval),
    .carry_i     (carry_reg),
    .page_i      (page_reg),
    .res_o       (res),
    .acc_we_o    (acc_we),
    .file_we_o   (file_we),
    .zero_we_o   (zero_we),
    .carry_we_o  (carry_we),
    .carry_new_o (carry_new),
    .target_o    (target)
  );

  // address phase capture; only whole-word single transfers are expected
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= `A_INSTR;
    end else begin
      dph_wr_reg <= addr_ok & hwrite_i;
      // hold address through the read wait state
      if (addr_ok) begin
        dph_addr_reg <= haddr_i[`A_LOW];
      end
    end
  end

  // reads take one wait state so data reflects every earlier write
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dph_rd_reg  <= 1'b0;
      hreadyout_o <= 1'b1;
    end else begin
      dph_rd_reg  <= addr_ok & ~hwrite_i;
      hreadyout_o <= ~(addr_ok & ~hwrite_i);
    end
  end

  // error response is never used
  always_ff @(posedge mclk_i) begin
    hresp_o <= 1'b0;
  end

  // read mux, registered at the end of the wait state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= `RD_ZERO;
    end else if (dph_rd_reg) begin
      if (hit(dph_addr_reg, `A_ACC)) begin
        hrdata_o <= {24'h00_0000, acc_reg};
      end else if (hit(dph_addr_reg, `A_STAT)) begin
        hrdata_o <= `RD_ZERO;
        hrdata_o[`STAT_C]    <= carry_reg;
        hrdata_o[`STAT_Z]    <= zero_reg;
        hrdata_o[`STAT_BUSY] <= busy_o;
      end else if (hit(dph_addr_reg, `A_PAGE)) begin
        hrdata_o <= {24'h00_0000, page_reg};
      end else if (hit(dph_addr_reg, `A_PC)) begin
        hrdata_o <= {19'h0_0000, pc_o};
      end else if (in_file(dph_addr_reg)) begin
        hrdata_o <= {24'h00_0000,
                     file_mem_reg[dph_addr_reg[`A_FILE_IDX]]};
      end else begin
        // instruction register and holes read as zero
        hrdata_o <= `RD_ZERO;
      end
    end
  end

  // sequencer: a write to the instruction register launches one op
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NOP;
      dst_reg   <= 1'b0;
      k_reg     <= 11'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_ok && hit(dph_addr_reg, `A_INSTR)) begin
            op_reg    <= op_e'(hwdata_i[`INSTR_OP]);
            dst_reg   <= hwdata_i[`INSTR_DST];
            k_reg     <= hwdata_i[`INSTR_K];
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // jump has no condition and always takes a second cycle
          if (op_reg == OP_JUMP_UNCONDITIONAL) begin
            state_reg <= ST_JUMP2; // [RULE_03]
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_JUMP2: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // busy flag mirrors the sequencer, registered for the port
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      busy_o <= wr_ok && hit(dph_addr_reg, `A_INSTR);
    end else begin
      busy_o <= (state_reg == ST_EXEC) &&
                (op_reg == OP_JUMP_UNCONDITIONAL);
    end
  end

  // program counter: target lands at end of second jump cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pc_o <= `RST_PC;
    end else if (state_reg == ST_JUMP2) begin
      pc_o <= target; // [RULE_01] [RULE_02]
    end else if (exec_now && op_reg != OP_JUMP_UNCONDITIONAL) begin
      // other operations simply step to the next word
      pc_o <= pc_o + `PC_STEP;
    end else if (wr_ok && hit(dph_addr_reg, `A_PC)) begin
      pc_o <= hwdata_i[`PC_W-1:0];
    end
  end

  // working register: datapath wins, bus may load it when idle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      acc_reg <= `RST_BYTE;
    end else if (exec_now && acc_we) begin
      acc_reg <= res; // [RULE_04] [RULE_05] [RULE_06] [RULE_07]
    end else if (wr_ok && hit(dph_addr_reg, `A_ACC)) begin
      acc_reg <= bus_byte;
    end
  end

  // flags: each op touches only its own flag
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (exec_now) begin
      if (zero_we) begin
        zero_reg <= (res == `RST_BYTE); // [RULE_04] [RULE_05] [RULE_06]
      end
      if (carry_we) begin
        carry_reg <= carry_new; // [RULE_07] [RULE_08]
      end
    end else if (wr_ok && hit(dph_addr_reg, `A_STAT)) begin
      carry_reg <= hwdata_i[`STAT_C];
      zero_reg  <= hwdata_i[`STAT_Z];
    end
  end

  // page latch, software only
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      page_reg <= `RST_BYTE;
    end else if (wr_ok && hit(dph_addr_reg, `A_PAGE)) begin
      page_reg <= bus_byte;
    end
  end

  // file registers: no reset, like ordinary data memory
  always_ff @(posedge mclk_i) begin
    if (exec_now && file_we) begin
      file_mem_reg[k_reg[`K_FILE]] <= res; // [RULE_05] [RULE_06]
    end else if (wr_ok && in_file(dph_addr_reg)) begin
      file_mem_reg[dph_addr_reg[`A_FILE_IDX]] <= bus_byte;
    end
  end

  // checks on the execution results
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence jump_start_s;
    exec_now && op_reg == OP_JUMP_UNCONDITIONAL;
  endsequence

  sequence jump_both_s;
    jump_start_s ##1 (state_reg == ST_JUMP2);
  endsequence

  jump_low_a: assert property ( // [RULE_01]
    jump_both_s |=> pc_o[10:0] == $past(k_reg, 2))
    else $error("jump low pc bits wrong");

  jump_page_a: assert property ( // [RULE_02]
    jump_both_s |=> pc_o[12:11] == $past(page_reg[4:3], 2))
    else $error("jump page bits wrong");

  jump_flags_a: assert property ( // [RULE_03]
    jump_start_s |=> (state_reg == ST_JUMP2) && $stable(carry_reg)
      && $stable(zero_reg) ##1 (state_reg == ST_IDLE)
      && $stable(carry_reg) && $stable(zero_reg))
    else $error("jump not two cycles or flags moved");

  or_literal_a: assert property ( // [RULE_04]
    exec_now && op_reg == OP_OR_LITERAL_INTO_ACC |=>
      acc_reg == ($past(acc_reg) | $past(k_reg[7:0]))
      && zero_reg == (acc_reg == 8'h00) && $stable(carry_reg))
    else $error("or literal result or flags wrong");

  inc_acc_a: assert property ( // [RULE_05]
    exec_now && op_reg == OP_INCREMENT_FILE && !dst_reg |=>
      acc_reg == 8'($past(fval) + 8'h01)
      && zero_reg == (acc_reg == 8'h00))
    else $error("increment into acc wrong");

  or_file_a: assert property ( // [RULE_06]
    exec_now && op_reg == OP_OR_ACC_WITH_FILE && dst_reg |=>
      file_mem_reg[$past(k_reg[6:0])] == ($past(acc_reg) | $past(fval))
      && $stable(acc_reg))
    else $error("or with file to file wrong");

  rotate_flags_a: assert property ( // [RULE_07]
    exec_now && op_reg == OP_ROTATE_LEFT_THRU_CARRY |=>
      $stable(zero_reg) && carry_reg == $past(fval[7]))
    else $error("rotate touched wrong flag");

  rotate_bits_a: assert property ( // [RULE_08]
    exec_now && op_reg == OP_ROTATE_LEFT_THRU_CARRY && !dst_reg |=>
      acc_reg == {$past(fval[6:0]), $past(carry_reg)})
    else $error("rotate bit order wrong");

endmodule
`default_nettype wire

// >>> rtl/exec_defs.svh
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// register byte offsets, compared against haddr[11:0]
`define A_INSTR      12'h000
`define A_ACC        12'h004
`define A_STAT       12'h008
`define A_PAGE       12'h00c
`define A_PC         12'h010
// file window: haddr[11:9] == 3'h1, file index in haddr[8:2]
`define A_FILE_HI    3'h1
`define A_FILE_SEL   11:9
`define A_FILE_IDX   8:2
`define A_LOW        11:0

// instruction word fields
`define INSTR_OP     2:0
`define INSTR_DST    3
`define INSTR_K      14:4

// status word bit positions
`define STAT_C       0
`define STAT_Z       2
`define STAT_BUSY    8

// operand field slices and jump target assembly
`define K_LOW        10:0
`define K_LIT        7:0
`define K_FILE       6:0
`define PAGE_HI      4:3
`define PC_W         13

// reset values and constants
`define RST_BYTE     8'h00
`define RST_PC       13'h0000
`define PC_STEP      13'h0001
`define BYTE_ONE     8'h01
`define FILE_DEPTH   128
`define RD_ZERO      32'h0000_0000

`endif

// >>> rtl/exec_pkg.sv
`default_nettype none
package exec_pkg;

  // operations that software can launch through the instruction register
  typedef enum logic [2:0] {
    OP_NOP                    = 3'h0,
    OP_JUMP_UNCONDITIONAL     = 3'h1,
    OP_OR_LITERAL_INTO_ACC    = 3'h2,
    OP_OR_ACC_WITH_FILE       = 3'h3,
    OP_INCREMENT_FILE         = 3'h4,
    OP_ROTATE_LEFT_THRU_CARRY = 3'h5
  } op_e;

  // sequencer states, gray along idle -> exec -> second jump cycle
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_JUMP2 = 2'b11
  } state_e;

endpackage
`default_nettype wire

// >>> rtl/exec_alu.sv
`include "exec_defs.svh"
`default_nettype none
// combinational datapath for one instruction
module exec_alu
  import exec_pkg::*;
(
  input  wire op_e          op_i,
  input  wire logic         dst_i,
  input  wire logic [10:0]  k_i,
  input  wire logic [7:0]   acc_i,
  input  wire logic [7:0]   fval_i,
  input  wire logic         carry_i,
  input  wire logic [7:0]   page_i,
  output logic [7:0]        res_o,
  output logic              acc_we_o,
  output logic              file_we_o,
  output logic              zero_we_o,
  output logic              carry_we_o,
  output logic              carry_new_o,
  output logic [12:0]       target_o
);

  // result, write enables and flag effects per operation
  always_comb begin
    res_o       = `RST_BYTE;
    acc_we_o    = 1'b0;
    file_we_o   = 1'b0;
    zero_we_o   = 1'b0;
    carry_we_o  = 1'b0;
    carry_new_o = carry_i;
    // page bits on top, operand below; no flag touched [RULE_01] [RULE_02]
    target_o    = {page_i[`PAGE_HI], k_i[`K_LOW]};
    case (op_i)
      OP_OR_LITERAL_INTO_ACC: begin
        // literal always lands in the accumulator [RULE_04]
        res_o     = acc_i | k_i[`K_LIT];
        acc_we_o  = 1'b1;
        zero_we_o = 1'b1;
      end
      OP_OR_ACC_WITH_FILE: begin
        res_o     = acc_i | fval_i; // [RULE_06]
        acc_we_o  = ~dst_i;
        file_we_o = dst_i;
        zero_we_o = 1'b1;
      end
      OP_INCREMENT_FILE: begin
        res_o     = fval_i + `BYTE_ONE; // wraps 0xff -> 0x00 [RULE_05]
        acc_we_o  = ~dst_i;
        file_we_o = dst_i;
        zero_we_o = 1'b1;
      end
      OP_ROTATE_LEFT_THRU_CARRY: begin
        // msb out to carry, old carry into lsb [RULE_07] [RULE_08]
        res_o       = {fval_i[6:0], carry_i};
        acc_we_o    = ~dst_i;
        file_we_o   = dst_i;
        carry_we_o  = 1'b1;
        carry_new_o = fval_i[7];
      end
      default: begin
        // jump and unknown codes write no data
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> sim/branch_or_inc_rotate_exec_tb_top.sv
`include "exec_defs.svh"
`default_nettype none
// self-checking bench: bus tasks plus call sequences with expected values
module branch_or_inc_rotate_exec_tb_top
  import exec_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WAIT_MAX = 40;  // bound on every handshake wait

  logic        mclk;       // 100 MHz bench clock
  logic        rst_n;      // synchronous reset, active low
  logic        hsel;       // slave select
  logic [31:0] haddr;      // bus address
  logic [1:0]  htrans;     // transfer type
  logic        hwrite;     // write strobe
  logic [2:0]  hsize;      // always a whole word
  logic [31:0] hwdata;     // write data
  logic        hready;     // bus ready, one slave only
  logic [31:0] hrdata;     // read data
  logic        hreadyout;  // slave ready
  logic        hresp;      // slave response
  logic [12:0] pc;         // program counter
  logic        busy;       // sequencer busy
  int          error_cnt;  // mismatches seen
  int          num_checks; // comparisons made

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  // clock source, half period 5 ns
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  branch_or_inc_rotate_exec i_dut (
    .mclk_i      (mclk),
    .rst_n_i     (rst_n),
    .hsel_i      (hsel),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (hsize),
    .hwdata_i    (hwdata),
    .hready_i    (hready),
    .hrdata_o    (hrdata),
    .hreadyout_o (hreadyout),
    .hresp_o     (hresp),
    .pc_o        (pc),
    .busy_o      (busy)
  );

  // verdict and end of run, the only exit
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one comparison, printed at once on mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wait until ready is sampled high at an edge; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < WAIT_MAX);
    if (hready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;  // data taken at the closing edge
  endtask

  // register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // register read compared with an expected word
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  // byte address of file register f
  function automatic logic [11:0] fa(input logic [6:0] f);
    return {`A_FILE_HI, f, 2'b00};
  endfunction

  // expected status word from carry and zero
  function automatic logic [31:0] st(input logic c, input logic z);
    return {29'h0, z, 1'b0, c};
  endfunction

  // launch one instruction and count the cycles busy stands high
  task automatic exec(input op_e op, input logic dst,
                      input logic [10:0] k, input int cyc);
    int n;
    int i;
    wr(`A_INSTR, {17'h0, k, dst, op});
    n = 0;
    i = 0;
    // loop bound counts edges, so an unknown busy cannot hang the run
    do begin
      @(posedge mclk);
      i++;
      if (busy === 1'b1) n++;
    end while (busy !== 1'b0 && i < WAIT_MAX);
    if (busy !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
    check(32'(n), 32'(cyc));
  endtask

  // main sequence
  initial begin
    error_cnt  = 0;
    num_checks = 0;
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // reset state
    check({19'h0, pc}, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    rd_chk(`A_ACC, 32'h0000_0000);
    rd_chk(`A_STAT, 32'h0000_0000);
    // or literal: zero result, carry must survive
    wr(`A_STAT, st(1'b1, 1'b0));
    exec(OP_OR_LITERAL_INTO_ACC, 1'b0, 11'h000, 1);
    rd_chk(`A_ACC, 32'h0000_0000);
    rd_chk(`A_STAT, st(1'b1, 1'b1));
    check({19'h0, pc}, 32'h0000_0001);
    // or literal: upper k bits are not part of the literal
    wr(`A_ACC, 32'h0000_0050);
    exec(OP_OR_LITERAL_INTO_ACC, 1'b1, 11'h7a5, 1);
    rd_chk(`A_ACC, 32'h0000_00f5);
    rd_chk(`A_STAT, st(1'b1, 1'b0));
    // increment wraps to zero into acc, file untouched
    wr(fa(7'h7f), 32'h0000_00ff);
    wr(`A_STAT, st(1'b0, 1'b0));
    exec(OP_INCREMENT_FILE, 1'b0, 11'h07f, 1);
    rd_chk(`A_ACC, 32'h0000_0000);
    rd_chk(fa(7'h7f), 32'h0000_00ff);
    rd_chk(`A_STAT, st(1'b0, 1'b1));
    // increment back into the file, acc untouched
    wr(fa(7'h05), 32'h0000_0041);
    exec(OP_INCREMENT_FILE, 1'b1, 11'h005, 1);
    rd_chk(fa(7'h05), 32'h0000_0042);
    rd_chk(`A_ACC, 32'h0000_0000);
    rd_chk(`A_STAT, st(1'b0, 1'b0));
    // or acc with file into acc
    wr(`A_ACC, 32'h0000_000f);
    wr(fa(7'h00), 32'h0000_00f0);
    exec(OP_OR_ACC_WITH_FILE, 1'b0, 11'h000, 1);
    rd_chk(`A_ACC, 32'h0000_00ff);
    rd_chk(fa(7'h00), 32'h0000_00f0);
    // or acc with file into file, zero result, carry kept
    wr(`A_ACC, 32'h0000_0000);
    wr(fa(7'h01), 32'h0000_0000);
    wr(`A_STAT, st(1'b1, 1'b0));
    exec(OP_OR_ACC_WITH_FILE, 1'b1, 11'h001, 1);
    rd_chk(fa(7'h01), 32'h0000_0000);
    rd_chk(`A_STAT, st(1'b1, 1'b1));
    // rotate: msb to carry, old carry to lsb, zero flag kept
    wr(`A_STAT, st(1'b0, 1'b1));
    wr(fa(7'h03), 32'h0000_0081);
    exec(OP_ROTATE_LEFT_THRU_CARRY, 1'b0, 11'h003, 1);
    rd_chk(`A_ACC, 32'h0000_0002);
    rd_chk(fa(7'h03), 32'h0000_0081);
    rd_chk(`A_STAT, st(1'b1, 1'b1));
    exec(OP_ROTATE_LEFT_THRU_CARRY, 1'b1, 11'h003, 1);
    rd_chk(fa(7'h03), 32'h0000_0003);
    wr(fa(7'h02), 32'h0000_0040);
    exec(OP_ROTATE_LEFT_THRU_CARRY, 1'b1, 11'h002, 1);
    rd_chk(fa(7'h02), 32'h0000_0081);
    rd_chk(`A_STAT, st(1'b0, 1'b1));
    // jumps: only page bits 4:3 reach the counter, two cycles each
    wr(`A_PAGE, 32'h0000_00e7);
    exec(OP_JUMP_UNCONDITIONAL, 1'b0, 11'h7ff, 2);
    check({19'h0, pc}, 32'h0000_07ff);
    wr(`A_PAGE, 32'h0000_0018);
    exec(OP_JUMP_UNCONDITIONAL, 1'b1, 11'h7ff, 2);
    check({19'h0, pc}, 32'h0000_1fff);
    rd_chk(`A_STAT, st(1'b0, 1'b1));
    // counter wraps on the next ordinary step
    exec(OP_OR_LITERAL_INTO_ACC, 1'b0, 11'h000, 1);
    check({19'h0, pc}, 32'h0000_0000);
    wr(`A_PAGE, 32'h0000_00f7);
    exec(OP_JUMP_UNCONDITIONAL, 1'b0, 11'h555, 2);
    check({19'h0, pc}, 32'h0000_1555);
    rd_chk(`A_STAT, st(1'b0, 1'b0));
    rd_chk(`A_PAGE, 32'h0000_00f7);
    // unmapped and write-only places read zero
    wr(12'h100, 32'h0000_00aa);
    rd_chk(12'h100, 32'h0000_0000);
    rd_chk(`A_INSTR, 32'h0000_0000);
    // pc is writable while idle
    wr(`A_PC, 32'h0000_0123);
    rd_chk(`A_PC, 32'h0000_0123);
    check({19'h0, pc}, 32'h0000_0123);
    // nop only steps the counter
    exec(OP_NOP, 1'b1, 11'h7ff, 1);
    check({19'h0, pc}, 32'h0000_0124);
    rd_chk(`A_ACC, 32'h0000_0002);
    rd_chk(`A_STAT, st(1'b0, 1'b0));
    // busy shows in status while a jump runs
    wr(`A_PAGE, 32'h0000_0008);
    wr(`A_INSTR, {17'h0, 11'h0aa, 1'b0, OP_JUMP_UNCONDITIONAL});
    rd_chk(`A_STAT, 32'h0000_0100);
    check({19'h0, pc}, 32'h0000_08aa);
    // a write landing mid-jump is dropped, the jump still completes
    wr(`A_INSTR, {17'h0, 11'h155, 1'b0, OP_JUMP_UNCONDITIONAL});
    wr(`A_ACC, 32'h0000_00ff);
    rd_chk(`A_ACC, 32'h0000_0002);
    check({19'h0, pc}, 32'h0000_0955);
    rd_chk(`A_STAT, st(1'b0, 1'b0));
    report_and_stop();
  end

endmodule
`default_nettype wire
